// ---- core/crbc_pkg.sv ----
// Purpose: shared constants for the charge reached_flag_a behaviour controller
// Assumes: two ports, behaviour code per port in two bits
// Notes:   widths of charge and threshold are fixed here
package crbc_pkg;
  localparam int          NPORT    = 2;
  localparam int          ACC_W    = 24;
  localparam int          DELTA_W  = 16;
  localparam logic [1:0]  BEH_REP  = 2'h0;
  localparam logic [1:0]  BEH_RD   = 2'h1;
  localparam logic [1:0]  BEH_DS   = 2'h2;
  localparam logic [1:0]  BEH_IGN  = 2'h3;
  localparam logic [1:0]  BEH_RST  = BEH_RD;
  localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;
  localparam logic [ACC_W-1:0] ACC_MAX = 24'hffffff;
endpackage : crbc_pkg

// ---- core/crbc_port_if.sv ----
// Purpose: per-port link between policy, accumulator and enable latch
// Assumes: single clock domain
// Notes:   one instance per port
`timescale 1ns/1ps
interface crbc_port_if;
  import crbc_pkg::*;
  logic               active;
  logic               enable;
  logic               clear;
  logic               inc;
  logic [DELTA_W-1:0] delta;
  logic [ACC_W-1:0]   thr;
  logic [ACC_W-1:0]   acc;
  logic               flag;
  logic               pe_in;
  logic               pe_hold;
  logic               pe_apply;
  logic               pe_eff;
  modport accum (input active, enable, clear, inc, delta, thr, output acc, flag);
  modport latch (input pe_in, pe_hold, pe_apply, output pe_eff);
  modport ctrl  (output active, enable, clear, inc, delta, thr, pe_in, pe_hold,
                 pe_apply, input acc, flag, pe_eff);
endinterface : crbc_port_if

// ---- core/crbc_accum.sv ----
// Purpose: saturating charge accumulator with threshold flag
// Assumes: increments arrive as one-cycle strobes
// Notes:   flag and count update in the same edge
`timescale 1ns/1ps
module crbc_accum
  import crbc_pkg::*;
(
  input wire logic clk_i,    // system clock
  input wire logic resetn_i, // async reset, active low
  crbc_port_if.accum pif     // accumulator side
);
  typedef struct packed {
    logic [ACC_W-1:0] acc;
    logic             flag;
  } crbc_acc_type;

  crbc_acc_type st;
  crbc_acc_type next_st;
  logic [ACC_W:0] sum;

  always_comb begin
    next_st = st;
    sum = {1'b0, st.acc} + {{(ACC_W+1-DELTA_W){1'b0}}, pif.delta};
    // attach or removal has no input here, so the count survives it
    if (pif.clear || !pif.enable) begin // R15 R22 R23 R2
      next_st.acc = ACC_RST;
    end else if (pif.active && pif.inc) begin // R1
      next_st.acc = sum[ACC_W] ? ACC_MAX : sum[ACC_W-1:0];
    end
    next_st.flag = pif.enable && !pif.clear &&
                   (st.flag || (pif.active && next_st.acc >= pif.thr)); // R24 R1
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{acc: ACC_RST, flag: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pif.acc  = st.acc;
  assign pif.flag = st.flag;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_idle_hold;
    (!pif.active && !pif.clear && pif.enable) |=> $stable(pif.acc);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("count moved outside active"); // R1

  property p_clear;
    (pif.clear || !pif.enable) |=> (pif.acc == ACC_RST) && !pif.flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left count or flag"); // R15

  property p_flag_cause;
    $rose(pif.flag) |-> (pif.acc >= pif.thr);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("flag set below threshold"); // R24
endmodule : crbc_accum

// ---- core/crbc_pe_latch.sv ----
// Purpose: effective port power enable as seen by the power states
// Assumes: hold and apply come from registered policy state
// Notes:   apply wins over hold
`timescale 1ns/1ps
module crbc_pe_latch
  import crbc_pkg::*;
(
  input wire logic clk_i,    // system clock
  input wire logic resetn_i, // async reset, active low
  crbc_port_if.latch pif     // enable latch side
);
  typedef struct packed {
    logic pe;
  } crbc_pe_type;

  crbc_pe_type st;
  crbc_pe_type next_st;

  always_comb begin
    next_st = st;
    if (pif.pe_apply || !pif.pe_hold) begin // R17 R13
      next_st.pe = pif.pe_in;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{pe: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pif.pe_eff = st.pe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_hold;
    (pif.pe_hold && !pif.pe_apply) |=> $stable(pif.pe_eff);
  endproperty
  a_hold: assert property (p_hold) else $error("enable moved while held"); // R13
endmodule : crbc_pe_latch

// ---- core/crbc_top.sv ----
// Purpose: per-port charge rationing behaviour controller
// Assumes: all inputs synchronous to clk_i; charge strobes from a meter
// Notes:   policy outputs follow the reached flag by one clock
//
// Overview of operation
// R1 - count charge and test the threshold only in the Active state
// R2 - attach or removal events never clear the accumulated charge
// R3 - port behaves normally in every behaviour until threshold reached
// R4 - writing a new behaviour leaves the charge data untouched
// R5 - behaviour change before threshold is silent, applied once threshold hits
// R6 - behaviour change after threshold acts at once on alert and switch
// R7 - behaviour codes: 00 report, 01 report+disconnect default, 10 sleep, 11 ignore
// R8 - report+disconnect at threshold asserts alert and opens the switch
// R9 - report+disconnect keeps bus monitoring running
// R10 - report+disconnect: enables still move states, switch stays open
// R11 - report+disconnect keeps the bypass switch open despite attach detect
// R12 - disconnect+sleep opens switch, enters Sleep, stops voltage monitoring
// R13 - disconnect+sleep ignores enable toggles until rationing is reset
// R14 - ignore takes no action at the threshold
// R15 - any rationing reset clears the charge and the reached flag
// R16 - reset in report modes releases the alert
// R17 - reset in disconnect modes re-samples enables and enters that state
// R18 - from ignore: alert, alert+open, or open+sleep per new behaviour
// R19 - from report: release, open, or release+open+sleep per new behaviour
// R20 - from report+disconnect: release+apply, apply, or release+sleep
// R21 - from sleep: apply, alert+apply, or alert+apply with switches open
// R22 - counter clear zeroes charge; restarts before, reset actions after
// R23 - clearing enable zeroes charge and undoes threshold actions
// R24 - reached flag sets in the cycle the charge meets the threshold
`timescale 1ns/1ps
module crbc_top
  import crbc_pkg::*;
(
  input  wire logic                          clk_i,                  // 200 MHz
  input  wire logic                          resetn_i,               // async, low
  input  wire logic [NPORT-1:0]              port_active_i,          // Active state
  input  wire logic [NPORT-1:0]              reached_flag_a_enable_i,        // rationing on
  input  wire logic [NPORT-1:0]              reached_flag_a_counter_clear_i, // clear pulse
  input  wire logic [NPORT-1:0][1:0]         reached_flag_a_behavior_sel_i,  // behaviour
  input  wire logic [NPORT-1:0]              charge_inc_i,           // charge strobe
  input  wire logic [NPORT-1:0][DELTA_W-1:0] charge_delta_i,         // charge step
  input  wire logic [NPORT-1:0][ACC_W-1:0]   reached_flag_a_threshold_i,     // limit
  input  wire logic [NPORT-1:0]              port_power_enable_i,    // enable ctrl
  output logic      [NPORT-1:0]              alert_n_o,              // alert, low
  output logic      [NPORT-1:0]              switch_open_o,          // force open
  output logic      [NPORT-1:0]              bypass_block_o,         // bypass off
  output logic      [NPORT-1:0]              sleep_req_o,            // go Sleep
  output logic      [NPORT-1:0]              monitor_stop_o,         // stop monitor
  output logic      [NPORT-1:0]              pe_apply_o,             // re-evaluate
  output logic      [NPORT-1:0]              pe_eff_o,               // held enable
  output logic      [NPORT-1:0]              reached_flag_a_o,       // reached flag
  output logic      [NPORT-1:0][ACC_W-1:0]   accum_charge_o          // total charge
);
  typedef struct packed {
    logic [NPORT-1:0]      alert_n;
    logic [NPORT-1:0]      sw_open;
    logic [NPORT-1:0]      byp_blk;
    logic [NPORT-1:0]      sleep;
    logic [NPORT-1:0]      mon_stop;
    logic [NPORT-1:0]      pe_apply;
    logic [NPORT-1:0]      reached_prev;
    logic [NPORT-1:0][1:0] beh_prev;
  } crbc_state_type;

  crbc_state_type st;
  crbc_state_type next_st;
  logic [NPORT-1:0] flag_w;

  for (genvar i = 0; i < NPORT; i++) begin : g_port
    crbc_port_if pif ();

    // behaviour select never reaches the accumulator
    assign pif.active   = port_active_i[i]; // R4
    assign pif.enable   = reached_flag_a_enable_i[i];
    assign pif.clear    = reached_flag_a_counter_clear_i[i];
    assign pif.inc      = charge_inc_i[i];
    assign pif.delta    = charge_delta_i[i];
    assign pif.thr      = reached_flag_a_threshold_i[i];
    assign pif.pe_in    = port_power_enable_i[i];
    assign pif.pe_hold  = st.sleep[i];
    assign pif.pe_apply = st.pe_apply[i];
    assign flag_w[i]    = pif.flag;
    assign reached_flag_a_o[i] = pif.flag;
    assign accum_charge_o[i]   = pif.acc;
    assign pe_eff_o[i]         = pif.pe_eff;

    crbc_accum u_accum (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .pif      (pif)
    );

    crbc_pe_latch u_pe (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .pif      (pif)
    );
  end

  // alert, switch, bypass, sleep and monitor stop are a pure function of flag and current behaviour;
  // only pe_apply keeps the previous flag and behaviour to tell the path of a change
  always_comb begin
    logic [1:0] beh;
    logic       r;
    logic       disc_now;
    logic       disc_prev;
    beh       = 2'h0;
    r         = 1'b0;
    disc_now  = 1'b0;
    disc_prev = 1'b0;
    next_st   = st;
    for (int p = 0; p < NPORT; p++) begin
      beh       = reached_flag_a_behavior_sel_i[p];
      r         = flag_w[p];
      disc_now  = (beh == BEH_RD) || (beh == BEH_DS);
      disc_prev = (st.beh_prev[p] == BEH_RD) || (st.beh_prev[p] == BEH_DS);
      // until the flag rises every output stays in the normal state
      next_st.alert_n[p]  = !(r && (beh == BEH_REP || beh == BEH_RD)); // R3 R5 R7 R16
      next_st.sw_open[p]  = r && disc_now;        // R8 R12 R6
      next_st.byp_blk[p]  = r && (beh == BEH_RD); // R11 R10 R21
      next_st.sleep[p]    = r && (beh == BEH_DS); // R12 R13
      next_st.mon_stop[p] = r && (beh == BEH_DS); // R9 R12
      // ignore sets nothing above, so it takes no action
      next_st.pe_apply[p] =                                              // R14
        (st.reached_prev[p] && !r && disc_now) ||                       // R17 R22 R23
        (st.reached_prev[p] && r && disc_prev &&
         beh != st.beh_prev[p] && beh != BEH_DS);                       // R20 R21
      next_st.reached_prev[p] = r;
      next_st.beh_prev[p]     = beh; // R18 R19
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st <= '{alert_n: '1, sw_open: '0, byp_blk: '0, sleep: '0, mon_stop: '0,
              pe_apply: '0, reached_prev: '0, beh_prev: {NPORT{BEH_RST}}};
    end else begin
      st <= next_st;
    end
  end

  assign alert_n_o      = st.alert_n;
  assign switch_open_o  = st.sw_open;
  assign bypass_block_o = st.byp_blk;
  assign sleep_req_o    = st.sleep;
  assign monitor_stop_o = st.mon_stop;
  assign pe_apply_o     = st.pe_apply;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  for (genvar k = 0; k < NPORT; k++) begin : g_chk
    sequence s_reach_rd;
      flag_w[k] && reached_flag_a_behavior_sel_i[k] == BEH_RD;
    endsequence
    sequence s_rd_actions;
      !alert_n_o[k] && switch_open_o[k] && bypass_block_o[k];
    endsequence
    sequence s_reach_ds;
      flag_w[k] && reached_flag_a_behavior_sel_i[k] == BEH_DS;
    endsequence
    sequence s_ds_actions;
      switch_open_o[k] && sleep_req_o[k] && monitor_stop_o[k] && alert_n_o[k];
    endsequence

    property p_rep_alert;
      (flag_w[k] && reached_flag_a_behavior_sel_i[k] == BEH_REP)
        |=> !alert_n_o[k] && !switch_open_o[k];
    endproperty
    a_rep_alert: assert property (p_rep_alert) else $error("report alert missing"); // R7

    property p_rd;
      s_reach_rd |=> s_rd_actions;
    endproperty
    a_rd: assert property (p_rd) else $error("disconnect actions missing"); // R8

    property p_rd_mon;
      (reached_flag_a_behavior_sel_i[k] == BEH_RD) |=> !monitor_stop_o[k] && !sleep_req_o[k];
    endproperty
    a_rd_mon: assert property (p_rd_mon) else $error("monitoring stopped"); // R9

    property p_ds;
      s_reach_ds |=> s_ds_actions;
    endproperty
    a_ds: assert property (p_ds) else $error("sleep actions missing"); // R12

    property p_ign;
      (reached_flag_a_behavior_sel_i[k] == BEH_IGN)
        |=> alert_n_o[k] && !switch_open_o[k] && !sleep_req_o[k];
    endproperty
    a_ign: assert property (p_ign) else $error("ignore took action"); // R14

    property p_normal;
      !flag_w[k] |=> alert_n_o[k] && !switch_open_o[k] && !bypass_block_o[k];
    endproperty
    a_normal: assert property (p_normal) else $error("action before threshold"); // R3

    property p_reset_apply;
      ($fell(flag_w[k]) && (reached_flag_a_behavior_sel_i[k] == BEH_RD ||
        reached_flag_a_behavior_sel_i[k] == BEH_DS)) |=> pe_apply_o[k] ##1 !pe_apply_o[k];
    endproperty
    a_reset_apply: assert property (p_reset_apply) else $error("no enable re-check"); // R17

    property p_ds_to_rd;
      (flag_w[k] && $past(flag_w[k]) && $past(reached_flag_a_behavior_sel_i[k]) == BEH_DS &&
       reached_flag_a_behavior_sel_i[k] == BEH_RD) |=> pe_apply_o[k] && switch_open_o[k];
    endproperty
    a_ds_to_rd: assert property (p_ds_to_rd) else $error("sleep to rd wrong"); // R21

    property p_release;
      $fell(flag_w[k]) |=> alert_n_o[k] && !switch_open_o[k] && !sleep_req_o[k];
    endproperty
    a_release: assert property (p_release) else $error("reset left actions"); // R16
  end
endmodule : crbc_top

// ---- testbench/crbc_power_model.sv ----
// Purpose: port power switch and power state seen by one port
// Assumes: Active whenever the held enable is on and no Sleep is asked
// Notes:   behavioural, answers in the same cycle
`timescale 1ns/1ps
module crbc_power_model
  import crbc_pkg::*;
(
  input  wire logic pe_eff_i,     // held enable
  input  wire logic sleep_req_i,  // Sleep request
  output logic      port_active_o // Active state
);
  // sleep wins over a held enable; counting gated on this state
  assign port_active_o = pe_eff_i & ~sleep_req_i;
endmodule : crbc_power_model

// ---- testbench/test_charge_reached_flag_a_behavior_ctrl.sv ----
// Purpose: self-checking bench for the reached_flag_a behaviour controller
// Assumes: policy outputs settle one clock after the reached flag
// Notes:   both ports exercised, one at a time
`timescale 1ns/1ps
module test_charge_reached_flag_a_behavior_ctrl;
  import crbc_pkg::*;
  logic                          clk = 0;
  logic                          resetn = 0;
  logic [NPORT-1:0]              en = '1, clr = '0, inc = '0, ppe = '1;
  logic [NPORT-1:0][1:0]         sel = {BEH_RD, BEH_RD};
  logic [NPORT-1:0][DELTA_W-1:0] delta = '0;
  logic [NPORT-1:0][ACC_W-1:0]   thr = {24'h000100, 24'h000100};
  wire  logic [NPORT-1:0]        act, alert_n, sw, byp, slp, mon, apply, pe_eff, flag;
  wire  logic [NPORT-1:0][ACC_W-1:0] acc;
  int                            err_count = 0;
  int                            n_compared = 0;

  always #2.5 clk = ~clk;

  crbc_top DUT (.clk_i(clk), .resetn_i(resetn), .port_active_i(act),
    .reached_flag_a_enable_i(en), .reached_flag_a_counter_clear_i(clr), .reached_flag_a_behavior_sel_i(sel),
    .charge_inc_i(inc), .charge_delta_i(delta), .reached_flag_a_threshold_i(thr),
    .port_power_enable_i(ppe), .alert_n_o(alert_n), .switch_open_o(sw),
    .bypass_block_o(byp), .sleep_req_o(slp), .monitor_stop_o(mon), .pe_apply_o(apply),
    .pe_eff_o(pe_eff), .reached_flag_a_o(flag), .accum_charge_o(acc));

  for (genvar g = 0; g < NPORT; g++) begin : g_pwr
    crbc_power_model u_pwr (.pe_eff_i(pe_eff[g]), .sleep_req_i(slp[g]), .port_active_o(act[g]));
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // alert_n, switch open, sleep, monitor stop once the threshold is reached
  function automatic logic [3:0] pol(input logic [1:0] s);
    pol = {~(s == BEH_REP || s == BEH_RD), s == BEH_RD || s == BEH_DS, s == BEH_DS, s == BEH_DS};
  endfunction : pol

  function automatic logic [3:0] obs(input int p);
    obs = {alert_n[p], sw[p], slp[p], mon[p]};
  endfunction : obs

  // leaves the bench one step after the taking edge, so count and flag are settled
  task automatic strobe(input int p, input logic [15:0] d);
    @(posedge clk);
    inc[p]   <= 1'b1;
    delta[p] <= d;
    @(posedge clk);
    inc[p] <= 1'b0;
    #1;
  endtask : strobe

  task automatic clear(input int p);
    @(posedge clk);
    clr[p] <= 1'b1;
    @(posedge clk);
    clr[p] <= 1'b0;
    tick(3);
  endtask : clear

  task automatic t_reset;
    check(24'(alert_n), 24'h3, "alert after reset");
    check(24'({sw, slp, flag}), 24'h0, "outputs after reset");
    check(acc[0], ACC_RST, "charge after reset");
    check(24'({byp, mon, apply}), 24'h0, "policy idle after reset");
  endtask : t_reset

  task automatic t_before(input int p);
    for (int s = 0; s < 4; s++) begin
      sel[p] <= 2'(s);
      strobe(p, 16'h0030);
      check(acc[p], 24'(16'h0030 * (s + 1)), "charge kept over sel change");
      tick(1);
      check(24'({flag[p], obs(p)}), 24'h08, "silent before threshold");
    end
    clear(p);
    check(acc[p], 24'h0, "clear before threshold");
    strobe(p, 16'h0030);
    check(acc[p], 24'h30, "restart after clear");
    clear(p);
  endtask : t_before

  task automatic t_hit(input int p);
    for (int s = 0; s < 4; s++) begin
      sel[p] <= 2'(s);
      tick(1);
      strobe(p, 16'h0100);
      check(24'(flag[p]), 24'h1, "flag at threshold");
      tick(1);
      check(24'(obs(p)), 24'(pol(2'(s))), "action at threshold");
      if (s == BEH_RD) begin
        check(24'(byp[p]), 24'h1, "bypass kept off");
        ppe[p] <= 1'b0;
        tick(3);
        check(24'({pe_eff[p], sw[p]}), 24'h1, "enable moves, switch open");
      end
      if (s == BEH_DS) begin
        ppe[p] <= 1'b0;
        tick(3);
        check(24'(pe_eff[p]), 24'h1, "enable frozen in sleep");
      end
      ppe[p] <= 1'b1;
      tick(3);
      clear(p);
      check(24'(flag[p]), 24'h0, "flag after rationing reset");
      check(acc[p], 24'h0, "charge after rationing reset");
      check(24'({obs(p), pe_eff[p]}), 24'h11, "released after reset");
    end
  endtask : t_hit

  task automatic t_change(input int p);
    for (int f = 0; f < 4; f++) begin
      for (int t = 0; t < 4; t++) begin
        if (f != t) begin
          sel[p] <= 2'(f);
          tick(1);
          strobe(p, 16'h0100);
          tick(1);
          sel[p] <= 2'(t);
          tick(2);
          check(24'(obs(p)), 24'(pol(2'(t))), "change after threshold");
          clear(p);
        end
      end
    end
  endtask : t_change

  task automatic t_disable(input int p);
    sel[p] <= BEH_RD;
    strobe(p, 16'h0100);
    tick(1);
    en[p] <= 1'b0;
    tick(2);
    check(24'(apply[p]), 24'h1, "enable re-check pulse");
    tick(1);
    check(24'(apply[p]), 24'h0, "re-check pulse ends");
    check(24'({flag[p], alert_n[p]}), 24'h1, "disable undoes");
    check(acc[p], 24'h0, "disable clears charge");
    en[p]  <= 1'b1;
    ppe[p] <= 1'b0;
    tick(3);
    strobe(p, 16'h0040);
    check(acc[p], 24'h0, "no count outside Active");
    ppe[p] <= 1'b1;
    tick(3);
  endtask : t_disable

  initial begin
    #100us;
    err_count++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    tick(3);
    t_reset();
    for (int p = 0; p < NPORT; p++) begin
      t_before(p);
      t_hit(p);
      check(24'(flag[1 - p]), 24'h0, "other port untouched");
    end
    t_change(0);
    t_disable(1);
    close_out();
  end
endmodule : test_charge_reached_flag_a_behavior_ctrl
